// [common/dse_defines.vh]
// Constants of the stream engine: address map, fields, codes and reset values
`ifndef DSE_DEFINES_VH
`define DSE_DEFINES_VH
// ==========================================================
// Structure
`define DSE_NSTR 2
`define DSE_FIFO_DEPTH 3'h4
`define DSE_DIRECT_DEPTH 3'h1
`define DSE_BEATS_1 3'h1
`define DSE_BEATS_BURST 3'h4
// ==========================================================
// Address decode: block in 7:5, word index in 4:2
`define DSE_A_BLK 7:5
`define DSE_A_IDX 4:2
`define DSE_BLK_STAT 3'h2
`define DSE_R_CTRL 3'h0
`define DSE_R_ITEMS 3'h1
`define DSE_R_PADDR 3'h2
`define DSE_R_MADDR 3'h3
`define DSE_R_FCTRL 3'h4
`define DSE_R_STAT 3'h0
`define DSE_R_TCCLR 3'h1
// ==========================================================
// Stream control fields
`define DSE_C_EN 0
`define DSE_C_PFC 5
`define DSE_C_DIR 7:6
`define DSE_C_CIRC 8
`define DSE_C_PINC 9
`define DSE_C_MINC 10
`define DSE_C_PSZ 12:11
`define DSE_C_MSZ 14:13
`define DSE_C_PRI 17:16
`define DSE_C_PBU 22:21
`define DSE_C_MBU 24:23
`define DSE_C_SEL 27:25
`define DSE_CTRL_MASK 32'h0FE37FE1
`define DSE_CNT_F 15:0
// ==========================================================
// FIFO control fields
`define DSE_F_THR 1:0
`define DSE_F_FIFO_ON 2
`define DSE_F_W 2:0
`define DSE_FCTRL_MASK 3'h7
// ==========================================================
// Codes
`define DSE_DIR_P2M 2'h0
`define DSE_DIR_M2P 2'h1
`define DSE_DIR_M2M 2'h2
`define DSE_BU_SINGLE 2'h0
// ==========================================================
// Reset values and steps
`define DSE_RST_W 32'h00000000
`define DSE_RST_CNT 16'h0000
`define DSE_RST_F 3'h0
`define DSE_RST_P 2'h0
`define DSE_RST_ACK 8'h00
`define DSE_ONE32 32'h00000001
`define DSE_CNT_ONE 16'h0001
`endif

// [rtl/dse_fifo.v]
// Four-entry item FIFO of one stream with a registered head word
`timescale 1ns/10ps
`include "dse_defines.vh"
module dse_fifo (
    input wire clock,
    input wire rst_n,
    input wire clr,
    input wire push,
    input wire [31:0] push_data,
    input wire pop,
    output reg [31:0] head_q,
    output reg [2:0] level_q
);
    reg [31:0] mem_q [0:3];
    reg [1:0] wp_q;
    reg [1:0] rp_q;
    wire [1:0] rp_d;

    // Next read pointer
    assign rp_d = clr ? `DSE_RST_P : (pop ? rp_q + 2'h1 : rp_q);

    // ==========================================================
    // Pointers, level and head register
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= `DSE_RST_P;
            rp_q <= `DSE_RST_P;
            level_q <= `DSE_RST_F;
            head_q <= `DSE_RST_W;
        end else begin
            rp_q <= rp_d;
            if (clr) begin
                wp_q <= `DSE_RST_P;
                level_q <= `DSE_RST_F;
            end else begin
                if (push) begin
                    wp_q <= wp_q + 2'h1;
                end
                level_q <= level_q + {2'h0, push} - {2'h0, pop};
            end
            // Bypass when the written slot becomes the head
            if (push && !clr && wp_q == rp_d) begin
                head_q <= push_data;
            end else begin
                head_q <= mem_q[rp_d];
            end
        end
    end

    // Storage
    always @(posedge clock) begin
        if (push && !clr) begin
            mem_q[wp_q] <= push_data;
        end
    end
endmodule // dse_fifo

// [rtl/dse_stream_engine.v]
// Multi-stream DMA engine: registers, arbitration and transfer sequencer
`timescale 1ns/10ps
`include "dse_defines.vh"
module dse_stream_engine #(
    parameter MEM2MEM_OK = 1
) (
    input wire clock,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire [7:0] periph_req,
    input wire [7:0] periph_last,
    output reg [7:0] periph_ack_q,
    output reg bus_req_q,
    output reg bus_we_q,
    output reg [31:0] bus_addr_q,
    output reg [1:0] bus_size_q,
    output reg [31:0] bus_wdata_q,
    input wire [31:0] bus_rdata,
    input wire bus_done
);
    localparam S_IDLE = 2'h0;
    localparam S_ISSUE = 2'h1;
    localparam S_BUS = 2'h2;
    localparam S_ACKW = 2'h3;
    localparam OP_PLOAD = 2'h0;
    localparam OP_PSTORE = 2'h1;
    localparam OP_MLOAD = 2'h2;
    localparam OP_MSTORE = 2'h3;

    // ==========================================================
    // State
    reg [31:0] ctrl_q [0:`DSE_NSTR-1];
    reg [15:0] cnt_q [0:`DSE_NSTR-1];
    reg [15:0] reload_q [0:`DSE_NSTR-1];
    reg [31:0] paddr_q [0:`DSE_NSTR-1];
    reg [31:0] maddr_q [0:`DSE_NSTR-1];
    reg [31:0] pbase_q [0:`DSE_NSTR-1];
    reg [31:0] mbase_q [0:`DSE_NSTR-1];
    reg [2:0] fctl_q [0:`DSE_NSTR-1];
    reg [`DSE_NSTR-1:0] drain_q;
    reg [`DSE_NSTR-1:0] tc_q;
    reg [1:0] st_q;
    reg [1:0] op_q;
    reg cur_q;
    reg [2:0] beats_q;
    reg [2:0] ack_ch_q;
    reg acked_q;
    reg last_q;
    reg pick;
    reg any_job;
    reg [1:0] best;
    reg [31:0] rd_d;
    integer s;
    integer k;

    wire [2:0] lvl_a [0:`DSE_NSTR-1];
    wire [31:0] head_a [0:`DSE_NSTR-1];
    wire [2:0] pb_a [0:`DSE_NSTR-1];
    wire [2:0] mb_a [0:`DSE_NSTR-1];
    wire [1:0] ms_a [0:`DSE_NSTR-1];
    wire [`DSE_NSTR-1:0] jp;
    wire [`DSE_NSTR-1:0] jm;
    wire [`DSE_NSTR-1:0] jx;
    wire [`DSE_NSTR-1:0] fin;
    wire [`DSE_NSTR-1:0] m2p_v;

    // Sequencer events
    wire idle = (st_q == S_IDLE);
    wire done_ev = (st_q == S_BUS) && bus_done;
    wire p_op = (op_q == OP_PLOAD) || (op_q == OP_PSTORE);
    wire ld_op = (op_q == OP_PLOAD) || (op_q == OP_MLOAD);
    wire dec_ev = done_ev && p_op && !ctrl_q[cur_q][`DSE_C_PFC];
    wire end_ev = dec_ev && (cnt_q[cur_q] == `DSE_CNT_ONE);
    wire stop = (beats_q == `DSE_BEATS_1) || end_ev;
    wire last_ev = done_ev && stop && last_q;
    wire [2:0] pick_ch = ctrl_q[pick][`DSE_C_SEL];

    // Register address decode
    wire [2:0] blk = reg_addr[`DSE_A_BLK];
    wire [2:0] idx = reg_addr[`DSE_A_IDX];
    wire rs = blk[0];

    // ==========================================================
    // Per-stream job conditions and FIFO
    genvar g;
    generate
        for (g = 0; g < `DSE_NSTR; g = g + 1) begin : g_str
            wire en = ctrl_q[g][`DSE_C_EN];
            wire pfc = ctrl_q[g][`DSE_C_PFC];
            wire [1:0] dir = ctrl_q[g][`DSE_C_DIR];
            wire m2m = (dir == `DSE_DIR_M2M) && (MEM2MEM_OK != 0);
            wire p2m = (dir == `DSE_DIR_P2M);
            wire dmd = fctl_q[g][`DSE_F_FIFO_ON];
            wire [2:0] cap = dmd ? `DSE_FIFO_DEPTH : `DSE_DIRECT_DEPTH;
            wire [2:0] thr = dmd ? ({1'b0, fctl_q[g][`DSE_F_THR]} + `DSE_BEATS_1)
                : `DSE_BEATS_1;
            wire [2:0] hi = (mb_a[g] > thr) ? mb_a[g] : thr;
            wire [2:0] room = cap - lvl_a[g];
            wire ch_req = periph_req[ctrl_q[g][`DSE_C_SEL]];
            wire cnt_ok = pfc || (cnt_q[g] != `DSE_RST_CNT);
            wire room_cnt = pfc || ({13'h0, lvl_a[g]} < cnt_q[g]);
            wire push = done_ev && (cur_q == g) && ld_op;
            wire pop = done_ev && (cur_q == g) && !ld_op;
            wire clr = idle && fin[g] && m2p_v[g];

            assign m2p_v[g] = (dir == `DSE_DIR_M2P);
            // Bursts only with the FIFO in use
            assign pb_a[g] = (dmd && ctrl_q[g][`DSE_C_PBU] != `DSE_BU_SINGLE)
                ? `DSE_BEATS_BURST : `DSE_BEATS_1;
            assign mb_a[g] = (dmd && ctrl_q[g][`DSE_C_MBU] != `DSE_BU_SINGLE)
                ? `DSE_BEATS_BURST : `DSE_BEATS_1;
            assign ms_a[g] = dmd ? ctrl_q[g][`DSE_C_MSZ] : ctrl_q[g][`DSE_C_PSZ];
            // Peripheral-side access on request
            assign jp[g] = en && !drain_q[g] && ch_req && cnt_ok
                && (m2p_v[g] ? (lvl_a[g] >= pb_a[g]) : (p2m && room >= pb_a[g]));
            // Memory side: prefetch or drain
            assign jm[g] = m2p_v[g]
                ? (en && !drain_q[g] && lvl_a[g] < cap && room_cnt)
                : (lvl_a[g] != `DSE_RST_F && (lvl_a[g] >= hi || drain_q[g]));
            // Memory-to-memory reads need no request
            assign jx[g] = en && m2m && !drain_q[g] && room != `DSE_RST_F && cnt_ok;
            // Completion once memory-bound data has left the FIFO
            assign fin[g] = drain_q[g] && (m2p_v[g] || lvl_a[g] == `DSE_RST_F);

            dse_fifo u_fifo (
                .clock(clock),
                .rst_n(rst_n),
                .clr(clr),
                .push(push),
                .push_data(bus_rdata),
                .pop(pop),
                .head_q(head_a[g]),
                .level_q(lvl_a[g])
            );
        end
    endgenerate

    // ==========================================================
    // Arbitration, strict compare keeps the lower stream on ties
    always @* begin
        pick = 1'b0;
        any_job = 1'b0;
        best = `DSE_RST_P;
        for (k = 0; k < `DSE_NSTR; k = k + 1) begin
            if ((jp[k] || jm[k] || jx[k])
                && (!any_job || ctrl_q[k][`DSE_C_PRI] > best)) begin
                pick = k[0];
                any_job = 1'b1;
                best = ctrl_q[k][`DSE_C_PRI];
            end
        end
    end

    // ==========================================================
    // Register file and stream bookkeeping
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (s = 0; s < `DSE_NSTR; s = s + 1) begin
                ctrl_q[s] <= `DSE_RST_W;
                cnt_q[s] <= `DSE_RST_CNT;
                reload_q[s] <= `DSE_RST_CNT;
                paddr_q[s] <= `DSE_RST_W;
                maddr_q[s] <= `DSE_RST_W;
                pbase_q[s] <= `DSE_RST_W;
                mbase_q[s] <= `DSE_RST_W;
                fctl_q[s] <= `DSE_RST_F;
            end
            drain_q <= {`DSE_NSTR{1'b0}};
            tc_q <= {`DSE_NSTR{1'b0}};
        end else begin
            for (s = 0; s < `DSE_NSTR; s = s + 1) begin
                // Software writes
                if (reg_wr && blk == s[2:0]) begin
                    case (idx)
                        `DSE_R_CTRL: begin
                            ctrl_q[s] <= reg_wdata & `DSE_CTRL_MASK;
                            if (ctrl_q[s][`DSE_C_EN] && !reg_wdata[`DSE_C_EN]) begin
                                drain_q[s] <= 1'b1;
                            end
                        end
                        `DSE_R_ITEMS: begin
                            cnt_q[s] <= reg_wdata[`DSE_CNT_F];
                            reload_q[s] <= reg_wdata[`DSE_CNT_F];
                        end
                        `DSE_R_PADDR: begin
                            paddr_q[s] <= reg_wdata;
                            pbase_q[s] <= reg_wdata;
                        end
                        `DSE_R_MADDR: begin
                            maddr_q[s] <= reg_wdata;
                            mbase_q[s] <= reg_wdata;
                        end
                        `DSE_R_FCTRL: begin
                            fctl_q[s] <= reg_wdata[`DSE_F_W] & `DSE_FCTRL_MASK;
                        end
                        default: begin
                        end
                    endcase
                end
                // Write-one clear of the complete flag; any set below wins
                if (reg_wr && blk == `DSE_BLK_STAT && idx == `DSE_R_TCCLR
                    && reg_wdata[s]) begin
                    tc_q[s] <= 1'b0;
                end
                if (idle && fin[s]) begin
                    tc_q[s] <= 1'b1;
                    drain_q[s] <= 1'b0;
                end
                // Address advance by item size
                if (done_ev && cur_q == s[0]) begin
                    if (p_op && ctrl_q[s][`DSE_C_PINC]) begin
                        paddr_q[s] <= paddr_q[s] + (`DSE_ONE32 << ctrl_q[s][`DSE_C_PSZ]);
                    end
                    if (!p_op && ctrl_q[s][`DSE_C_MINC]) begin
                        maddr_q[s] <= maddr_q[s] + (`DSE_ONE32 << ms_a[s]);
                    end
                end
                // Remaining-item count
                if (end_ev && cur_q == s[0]) begin
                    if (ctrl_q[s][`DSE_C_CIRC]) begin
                        cnt_q[s] <= reload_q[s];
                        paddr_q[s] <= pbase_q[s];
                        maddr_q[s] <= mbase_q[s];
                        tc_q[s] <= 1'b1;
                    end else begin
                        cnt_q[s] <= `DSE_RST_CNT;
                        ctrl_q[s][`DSE_C_EN] <= 1'b0;
                        drain_q[s] <= 1'b1;
                    end
                end else if (dec_ev && cur_q == s[0]) begin
                    cnt_q[s] <= cnt_q[s] - `DSE_CNT_ONE;
                end
                // Last request under peripheral flow control
                if (last_ev && cur_q == s[0]) begin
                    ctrl_q[s][`DSE_C_EN] <= 1'b0;
                    drain_q[s] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Transfer sequencer and bus master
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            op_q <= OP_PLOAD;
            cur_q <= 1'b0;
            beats_q <= `DSE_BEATS_1;
            ack_ch_q <= `DSE_RST_F;
            acked_q <= 1'b0;
            last_q <= 1'b0;
            periph_ack_q <= `DSE_RST_ACK;
            bus_req_q <= 1'b0;
            bus_we_q <= 1'b0;
            bus_addr_q <= `DSE_RST_W;
            bus_size_q <= `DSE_RST_P;
            bus_wdata_q <= `DSE_RST_W;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (any_job) begin
                        cur_q <= pick;
                        st_q <= S_ISSUE;
                        acked_q <= jp[pick];
                        last_q <= 1'b0;
                        if (jp[pick]) begin
                            op_q <= m2p_v[pick] ? OP_PSTORE : OP_PLOAD;
                            beats_q <= pb_a[pick];
                            ack_ch_q <= pick_ch;
                            periph_ack_q[pick_ch] <= 1'b1;
                            last_q <= ctrl_q[pick][`DSE_C_PFC] && periph_last[pick_ch];
                        end else if (jm[pick]) begin
                            op_q <= m2p_v[pick] ? OP_MLOAD : OP_MSTORE;
                            // Full burst on memory writes when enough data, else single; memory reads always single
                            if (!m2p_v[pick] && lvl_a[pick] >= mb_a[pick]) begin
                                beats_q <= mb_a[pick];
                            end else begin
                                beats_q <= `DSE_BEATS_1;
                            end
                        end else begin
                            op_q <= OP_PLOAD;
                            beats_q <= `DSE_BEATS_1;
                        end
                    end
                end
                S_ISSUE: begin
                    bus_req_q <= 1'b1;
                    bus_we_q <= !ld_op;
                    bus_addr_q <= p_op ? paddr_q[cur_q] : maddr_q[cur_q];
                    bus_size_q <= p_op ? ctrl_q[cur_q][`DSE_C_PSZ] : ms_a[cur_q];
                    bus_wdata_q <= ld_op ? `DSE_RST_W : head_a[cur_q]; // No unknowns on reads
                    st_q <= S_BUS;
                end
                S_BUS: begin
                    if (bus_done) begin
                        bus_req_q <= 1'b0;
                        beats_q <= beats_q - `DSE_BEATS_1;
                        if (!stop) begin
                            st_q <= S_ISSUE;
                        end else if (acked_q) begin
                            st_q <= S_ACKW;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_ACKW: begin
                    // Hold acknowledge until the request has gone
                    if (!periph_req[ack_ch_q]) begin
                        periph_ack_q <= `DSE_RST_ACK;
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Read data, valid only in the cycle after the strobe
    always @* begin
        rd_d = `DSE_RST_W;
        if (blk == `DSE_BLK_STAT) begin
            if (idx == `DSE_R_STAT) begin
                rd_d = {{(32-`DSE_NSTR){1'b0}}, tc_q};
            end
        end else if (blk < `DSE_NSTR) begin
            case (idx)
                `DSE_R_CTRL: rd_d = ctrl_q[rs];
                `DSE_R_ITEMS: rd_d = {16'h0000, cnt_q[rs]};
                `DSE_R_PADDR: rd_d = paddr_q[rs];
                `DSE_R_MADDR: rd_d = maddr_q[rs];
                `DSE_R_FCTRL: rd_d = {26'h0000000, lvl_a[rs], fctl_q[rs]};
                default: rd_d = `DSE_RST_W;
            endcase
        end
    end

    // Read data register
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= `DSE_RST_W;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_d;
        end else begin
            reg_rdata_q <= `DSE_RST_W;
        end
    end
endmodule // dse_stream_engine

// [verif/dse_periph_model.sv]
// Requesting peripherals and memory bus responder
`timescale 1ns/10ps
module dse_periph_model (
    input logic clock,
    input logic rst_n,
    input logic [7:0] fire,
    input logic [7:0] fire_last,
    input logic slow,
    input logic [7:0] periph_ack_q,
    input logic bus_req_q,
    input logic bus_we_q,
    input logic [31:0] bus_addr_q,
    input logic [31:0] bus_wdata_q,
    output logic [7:0] periph_req,
    output logic [7:0] periph_last,
    output logic [31:0] bus_rdata,
    output logic bus_done
);
    logic [31:0] rq[$];
    logic [31:0] wq[$];
    logic [31:0] wa[$];
    logic [31:0] nv;
    logic [1:0] wt;
    initial begin
        periph_req = 8'h00;
        periph_last = 8'h00;
        bus_rdata = 32'h00000000;
        bus_done = 1'b0;
        wt = 2'h0;
    end
    // Request lines, then bus answers after a prompt or slow wait
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            periph_req <= 8'h00;
            periph_last <= 8'h00;
            bus_done <= 1'b0;
            wt <= 2'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (fire[i] && !periph_ack_q[i]) begin
                    periph_req[i] <= 1'b1;
                    periph_last[i] <= fire_last[i];
                end else if (periph_ack_q[i]) begin
                    periph_req[i] <= 1'b0;
                    periph_last[i] <= 1'b0;
                end
            end
            nv = $urandom;
            bus_rdata <= nv; // Never a stale value
            bus_done <= 1'b0;
            if (bus_req_q && !bus_done && wt != 2'h0) begin
                wt <= wt - 2'h1;
            end else if (bus_req_q && !bus_done) begin
                bus_done <= 1'b1;
                wt <= slow ? 2'h3 : 2'h0;
                if (bus_we_q) begin
                    wq.push_back(bus_wdata_q);
                    wa.push_back(bus_addr_q);
                end else begin
                    rq.push_back(nv);
                end
            end
        end
    end
endmodule // dse_periph_model

// [verif/dse_props.sv]
// Port-level checks of the stream engine handshake and bus master
`timescale 1ns/10ps
module dse_props (
    input logic clock,
    input logic rst_n,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata_q,
    input logic [7:0] periph_req,
    input logic [7:0] periph_last,
    input logic [7:0] periph_ack_q,
    input logic bus_req_q,
    input logic bus_we_q,
    input logic [31:0] bus_addr_q,
    input logic [1:0] bus_size_q,
    input logic [31:0] bus_wdata_q,
    input logic [31:0] bus_rdata,
    input logic bus_done
);
    // ==========================================================
    // Handshake and bus checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_ack_on_req: assert property ((periph_ack_q & ~$past(periph_ack_q) & ~$past(periph_req)) == 8'h00)
        else $error("acknowledge raised without request");
    a_ack_drop_late: assert property ((~periph_ack_q & $past(periph_ack_q) & $past(periph_req)) == 8'h00)
        else $error("acknowledge dropped while request high");
    a_one_grant: assert property ($onehot0(periph_ack_q & ~$past(periph_ack_q)))
        else $error("two grants at once");
    a_ack_then_bus: assert property ((periph_ack_q & ~$past(periph_ack_q)) != 8'h00 |-> ##[0:2] bus_req_q)
        else $error("grant without bus access");
    a_bus_hold: assert property (bus_req_q && !bus_done |=> bus_req_q && $stable(bus_addr_q)
        && $stable(bus_we_q) && $stable(bus_size_q) && $stable(bus_wdata_q))
        else $error("bus access changed before done");
    a_bus_release: assert property (bus_req_q && bus_done |=> !bus_req_q)
        else $error("bus request held after done");
    a_size_legal: assert property (bus_req_q |-> bus_size_q != 2'h3)
        else $error("illegal item width");
    a_read_slot: assert property (reg_rdata_q != 32'h00000000 |-> $past(reg_rd))
        else $error("read data outside its slot");
endmodule // dse_props

// [verif/dse_stream_engine_tb_top.sv]
// Self-checking bench of the stream engine
`timescale 1ns/10ps
module dse_stream_engine_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] fire = 8'h00;
    logic [7:0] fire_last = 8'h00;
    logic slow = 1'b0;
    logic [31:0] reg_rdata_q, bus_addr_q, bus_wdata_q, bus_rdata, w, pa, ma;
    logic [7:0] periph_req, periph_last, periph_ack_q;
    logic [1:0] bus_size_q, psz;
    logic bus_req_q, bus_we_q, bus_done;
    logic [2:0] sel;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40, 8'hE0};
    dse_stream_engine u_dse_stream_engine (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .periph_req(periph_req), .periph_last(periph_last), .periph_ack_q(periph_ack_q),
        .bus_req_q(bus_req_q), .bus_we_q(bus_we_q), .bus_addr_q(bus_addr_q),
        .bus_size_q(bus_size_q), .bus_wdata_q(bus_wdata_q), .bus_rdata(bus_rdata),
        .bus_done(bus_done));
    dse_periph_model u_dse_periph_model (.clock(clock), .rst_n(rst_n), .fire(fire),
        .fire_last(fire_last), .slow(slow), .periph_ack_q(periph_ack_q), .bus_req_q(bus_req_q),
        .bus_we_q(bus_we_q), .bus_addr_q(bus_addr_q), .bus_wdata_q(bus_wdata_q),
        .periph_req(periph_req), .periph_last(periph_last), .bus_rdata(bus_rdata),
        .bus_done(bus_done));
    // Clock and hang limit
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic [31:0] mask(input logic [31:0] v);
        mask = psz == 2'h0 ? v & 32'hFF : psz == 2'h1 ? v & 32'hFFFF : v;
    endfunction
    // ==========================================================
    // Register bus and request drivers
    task automatic rst();
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 w = reg_rdata_q;
    endtask
    task automatic preq(input logic lst);
        @(posedge clock);
        fire[sel] <= 1'b1;
        fire_last[sel] <= lst;
        @(posedge clock);
        fire <= 8'h00;
        @(posedge clock);
        repeat (300) if (periph_req[sel] | periph_ack_q[sel]) @(negedge clock);
    endtask
    task automatic wwait(input int n);
        repeat (400) if (u_dse_periph_model.wq.size() < n) @(negedge clock);
        repeat (8) @(negedge clock);
    endtask
    // Random stream setup: top priority for direct mode, never direct memory-to-memory
    task automatic setup(input logic [7:0] b, input logic [1:0] dir, input logic pfc, input int n);
        sel = 3'($urandom % 8);
        psz = 2'($urandom % 3);
        pa = $urandom & 32'hFFFFFFF0;
        ma = $urandom & 32'hFFFFFFF0;
        slow <= 1'($urandom);
        u_dse_periph_model.rq.delete();
        u_dse_periph_model.wq.delete();
        u_dse_periph_model.wa.delete();
        wr(b + 8'h04, 32'(n));
        wr(b + 8'h08, pa);
        wr(b + 8'h0C, ma);
        wr(b + 8'h10, $urandom & 32'h3);
        wr(b, 32'h00030401 | (32'(pfc) << 5) | (32'(dir) << 6) | (32'(psz) << 11)
            | (($urandom % 3) << 13) | (($urandom % 16) << 21) | (32'(sel) << 25));
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hE97D1AF5));
        rst();
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(w, 32'h00000000);
        end
        for (int s = 0; s < 2; s++) begin
            pa = $urandom & 32'h0FE37FE0;
            wr(8'(s * 32), pa);
            rd(8'(s * 32));
            chk(w, pa);
            wr(8'(s * 32), 32'h00000000);
        end
        $display("test registers done");
        setup(8'h00, 2'h0, 1'b0, 3);
        for (int i = 0; i < 3; i++) preq(1'b0);
        wwait(3);
        for (int i = 0; i < 3; i++) begin
            chk(mask(u_dse_periph_model.wq[i]), mask(u_dse_periph_model.rq[i]));
            chk(u_dse_periph_model.wa[i], ma + (32'(i) << psz));
        end
        rd(8'h04);
        chk(w, 32'h00000000);
        rd(8'h00);
        chk(w & 32'h1, 32'h0);
        @(posedge clock) fire[sel] <= 1'b1;
        @(posedge clock) fire <= 8'h00;
        repeat (20) @(negedge clock);
        chk(32'(periph_ack_q), 32'h0);
        rst();
        $display("test periph to memory done");
        setup(8'h20, 2'h1, 1'b0, 2);
        repeat (12) @(negedge clock);
        chk(32'(u_dse_periph_model.rq.size()), 32'h1);
        preq(1'b0);
        preq(1'b0);
        wwait(2);
        for (int i = 0; i < 2; i++) begin
            chk(mask(u_dse_periph_model.wq[i]), mask(u_dse_periph_model.rq[i]));
            chk(u_dse_periph_model.wa[i], pa);
        end
        rd(8'h40);
        chk(w & 32'h2, 32'h2);
        rd(8'h20);
        chk(w & 32'h1, 32'h0);
        wr(8'h44, 32'h2);
        rd(8'h40);
        chk(w & 32'h2, 32'h0);
        $display("test memory to periph done");
        setup(8'h00, 2'h0, 1'b0, 5);
        preq(1'b0);
        preq(1'b0);
        wwait(2);
        wr(8'h00, 32'h00000000);
        repeat (12) @(negedge clock);
        rd(8'h40);
        chk(w & 32'h1, 32'h1);
        chk(32'(u_dse_periph_model.wq.size()), 32'h2);
        rd(8'h04);
        chk(w, 32'h3);
        wr(8'h44, 32'h1);
        $display("test disable done");
        setup(8'h00, 2'h0, 1'b1, 7);
        preq(1'b0);
        preq(1'b0);
        preq(1'b1);
        wwait(3);
        rd(8'h40);
        chk(w & 32'h1, 32'h1);
        chk(32'(u_dse_periph_model.wq.size()), 32'h3);
        $display("test periph flow done");
        complete_run();
    end
endmodule // dse_stream_engine_tb_top
bind dse_stream_engine dse_props u_dse_props (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .periph_req(periph_req), .periph_last(periph_last), .periph_ack_q(periph_ack_q),
    .bus_req_q(bus_req_q), .bus_we_q(bus_we_q), .bus_addr_q(bus_addr_q),
    .bus_size_q(bus_size_q), .bus_wdata_q(bus_wdata_q), .bus_rdata(bus_rdata),
    .bus_done(bus_done));
